/* ric_ctrl.sv */
// Execution control for the three return instructions of the core.
// Assumes the fetch stage holds req until it is taken while busy is low,
// and that the stack, program counter and working register live outside.
`timescale 1ns/1ps
`include "ric_defines.svh"

module ric_ctrl (
    input wire logic ref_clk,
    input wire logic resetn,
    input ric_pkg::ric_req_t req,
    input wire logic [`RIC_PC_W-1:0] stack_top,
    output logic busy,
    output logic done,
    output logic stack_pop,
    output logic pc_load,
    output logic [`RIC_PC_W-1:0] pc_value,
    output logic w_load,
    output logic [`RIC_DATA_W-1:0] w_value,
    output logic global_irq_enable_set,
    output logic [2:0] irq_control_bit,
    output logic status_write
);

    ric_pkg::ric_state_t s_q;
    ric_pkg::ric_state_t s_d;
    logic take;
    logic last_cycle;

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle counting

    assign take = req.valid && !s_q.busy && (req.op != ric_pkg::RIC_OP_NONE);

    ric_cycle_cnt u_cnt (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(take),
        .last(last_cycle)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.eff.stack_pop = 1'b0;
        s_d.eff.pc_load = 1'b0;
        s_d.eff.w_load = 1'b0;
        s_d.eff.global_irq_enable_set = 1'b0;
        s_d.eff.status_write = 1'b0;
        unique case (s_q.fsm)
            ric_pkg::RIC_ST_IDLE: begin
                if (take) begin
                    s_d.fsm = ric_pkg::RIC_ST_EXEC;
                    s_d.busy = 1'b1;
                    s_d.op = req.op;
                    // First cycle: pop and reload the program counter
                    s_d.eff.stack_pop = 1'b1;
                    s_d.eff.pc_load = 1'b1;
                    s_d.eff.pc_value = stack_top;
                    if (req.op == ric_pkg::RIC_OP_RETURN_WITH_LITERAL) begin
                        s_d.eff.w_load = 1'b1;
                        s_d.eff.w_value = req.literal;
                    end
                    if (req.op == ric_pkg::RIC_OP_RETURN_FROM_IRQ) begin
                        s_d.eff.global_irq_enable_set = 1'b1;
                    end
                end
            end
            ric_pkg::RIC_ST_EXEC: begin
                // Second cycle flushes the prefetched word
                s_d.fsm = ric_pkg::RIC_ST_FLUSH;
            end
            ric_pkg::RIC_ST_FLUSH: begin
                if (last_cycle) begin
                    s_d.fsm = ric_pkg::RIC_ST_IDLE;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                    s_d.op = ric_pkg::RIC_OP_NONE;
                end
            end
            default: begin
                s_d.fsm = ric_pkg::RIC_ST_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
    assign stack_pop = s_q.eff.stack_pop;
    assign pc_load = s_q.eff.pc_load;
    assign pc_value = s_q.eff.pc_value;
    assign w_load = s_q.eff.w_load;
    assign w_value = s_q.eff.w_value;
    assign global_irq_enable_set = s_q.eff.global_irq_enable_set;
    assign irq_control_bit = 3'(`RIC_IRQ_ENABLE_BIT);
    assign status_write = s_q.eff.status_write;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    a_pop_loads_pc: assert property (@(posedge ref_clk) disable iff (!resetn)
        take |=> stack_pop && pc_load && pc_value == $past(stack_top))
        else $error("return did not pop stack into program counter");

    a_irq_enable_on: assert property (@(posedge ref_clk) disable iff (!resetn)
        take |=> global_irq_enable_set == ($past(req.op) == ric_pkg::RIC_OP_RETURN_FROM_IRQ))
        else $error("interrupt enable set mismatch");

    a_irq_two_cycles: assert property (@(posedge ref_clk) disable iff (!resetn)
        take && req.op == ric_pkg::RIC_OP_RETURN_FROM_IRQ |=> busy [*2] ##1 (done && !busy))
        else $error("interrupt return not two cycles");

    a_literal_to_w: assert property (@(posedge ref_clk) disable iff (!resetn)
        take |=> (w_load == ($past(req.op) == ric_pkg::RIC_OP_RETURN_WITH_LITERAL))
            && (!w_load || w_value == $past(req.literal)))
        else $error("literal return working register mismatch");

    a_literal_two_cycles: assert property (@(posedge ref_clk) disable iff (!resetn)
        take && req.op == ric_pkg::RIC_OP_RETURN_WITH_LITERAL |-> ##3 $rose(done))
        else $error("literal return not two cycles");

    a_sub_ret_cycles: assert property (@(posedge ref_clk) disable iff (!resetn)
        take && req.op == ric_pkg::RIC_OP_RETURN_SUB |=> pc_load ##1 (!pc_load && busy) ##1 done)
        else $error("subroutine return sequence wrong");

    a_single_pop: assert property (@(posedge ref_clk) disable iff (!resetn)
        stack_pop |=> !stack_pop [*2])
        else $error("stack popped twice for one return");

    a_no_status: assert property (@(posedge ref_clk) disable iff (!resetn)
        busy || done |-> !status_write)
        else $error("return touched status flags");

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the effects of a return

    a_pop_from_take: assert property (@(posedge ref_clk) disable iff (!resetn)
        stack_pop |-> $past(take))
        else $error("stack popped without a taken return");

    a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
        !busy |-> !stack_pop && !pc_load && !w_load && !global_irq_enable_set)
        else $error("return effect outside a return");

    a_pc_value_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
        !pc_load |-> $stable(pc_value))
        else $error("program counter value changed without a load");

    a_none_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
        !busy && req.valid && req.op == ric_pkg::RIC_OP_NONE |=> !busy)
        else $error("empty request started a return");

    a_enable_only_irq: assert property (@(posedge ref_clk) disable iff (!resetn)
        global_irq_enable_set |->
            $past(take) && $past(req.op) == ric_pkg::RIC_OP_RETURN_FROM_IRQ)
        else $error("interrupt enable set by another return");

    a_w_value_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
        !w_load |-> $stable(w_value))
        else $error("working register value changed without a load");

    a_w_only_literal: assert property (@(posedge ref_clk) disable iff (!resetn)
        w_load |->
            $past(take) && $past(req.op) == ric_pkg::RIC_OP_RETURN_WITH_LITERAL)
        else $error("working register loaded by another return");

    a_literal_pc_top: assert property (@(posedge ref_clk) disable iff (!resetn)
        take && req.op == ric_pkg::RIC_OP_RETURN_WITH_LITERAL |=>
            busy && pc_value == $past(stack_top))
        else $error("literal return did not reload program counter");

    a_sub_keeps_w: assert property (@(posedge ref_clk) disable iff (!resetn)
        take && req.op == ric_pkg::RIC_OP_RETURN_SUB |=> !w_load && !global_irq_enable_set)
        else $error("subroutine return touched working register or enable");

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the cycle count

    a_take_starts_busy: assert property (@(posedge ref_clk) disable iff (!resetn)
        take |=> busy && !done)
        else $error("taken return did not raise busy");

    a_busy_two_cycles: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(busy) |=> busy ##1 !busy)
        else $error("busy did not last two cycles");

    a_no_take_busy: assert property (@(posedge ref_clk) disable iff (!resetn)
        busy |=> !stack_pop)
        else $error("request taken while busy");

    a_flush_no_effect: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(busy) && busy |-> !stack_pop && !pc_load)
        else $error("second cycle of a return had an effect");

    a_last_in_flush: assert property (@(posedge ref_clk) disable iff (!resetn)
        last_cycle |-> s_q.fsm == ric_pkg::RIC_ST_FLUSH)
        else $error("cycle counter out of step with sequencer");

    a_flush_one_cycle: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.fsm == ric_pkg::RIC_ST_FLUSH |=> s_q.fsm == ric_pkg::RIC_ST_IDLE)
        else $error("flush cycle did not end the return");

    a_done_ends_busy: assert property (@(posedge ref_clk) disable iff (!resetn)
        done |-> !busy && $past(busy))
        else $error("done not at the end of busy");

    a_done_after_two: assert property (@(posedge ref_clk) disable iff (!resetn)
        done |-> $past(busy, 2) && $past(busy))
        else $error("done without two busy cycles");

    a_done_one_cycle: assert property (@(posedge ref_clk) disable iff (!resetn)
        done |=> !done)
        else $error("done longer than one cycle");

endmodule // ric_ctrl

/* ric_defines.svh */
// Constants of the return instruction control block: widths, cycle counts, bit positions.
// Assumes a single instruction clock; one instruction cycle is one ref_clk period.
//
// Contract
// - Interrupt return pops the return stack and loads the program counter from it.
// - Interrupt return sets the global interrupt enable, bit 7 of the control register.
// - Interrupt return is one program word and finishes in two instruction cycles.
// - Literal return loads the working register with its eight-bit immediate.
// - Literal return loads the program counter from the stack top, two cycles.
// - Subroutine return pops the stack into the program counter, two cycles.
`ifndef RIC_DEFINES_SVH
`define RIC_DEFINES_SVH

`define RIC_PC_W 13
`define RIC_DATA_W 8
`define RIC_IRQ_ENABLE_BIT 7
`define RIC_RET_CYCLES 2
`define RIC_CNT_W 2
`define RIC_CLK_PERIOD_NS 20

`endif

/* ric_pkg.sv */
// Types of the return instruction control block.
// Assumes ric_defines.svh is on the include path.
`include "ric_defines.svh"

package ric_pkg;

    typedef enum logic [1:0] {
        RIC_OP_NONE,
        RIC_OP_RETURN_SUB,
        RIC_OP_RETURN_FROM_IRQ,
        RIC_OP_RETURN_WITH_LITERAL
    } ric_op_t;

    typedef enum logic [1:0] {
        RIC_ST_IDLE,
        RIC_ST_EXEC,
        RIC_ST_FLUSH
    } ric_fsm_t;

    // Decoded instruction offered by the fetch stage
    typedef struct packed {
        logic valid;
        ric_op_t op;
        logic [`RIC_DATA_W-1:0] literal;
    } ric_req_t;

    // Effects issued to the core datapath
    typedef struct packed {
        logic stack_pop;
        logic pc_load;
        logic [`RIC_PC_W-1:0] pc_value;
        logic w_load;
        logic [`RIC_DATA_W-1:0] w_value;
        logic global_irq_enable_set;
        logic status_write;
    } ric_eff_t;

    typedef struct packed {
        ric_fsm_t fsm;
        logic busy;
        logic done;
        ric_op_t op;
        ric_eff_t eff;
    } ric_state_t;

    typedef struct packed {
        logic [`RIC_CNT_W-1:0] left;
    } ric_cnt_state_t;

endpackage

/* ric_cycle_cnt.sv */
// Instruction cycle counter: counts down the cycles of a multi-cycle instruction.
// Assumes start is only pulsed while the count is idle.
`timescale 1ns/1ps
`include "ric_defines.svh"

module ric_cycle_cnt #(
    parameter logic [`RIC_CNT_W-1:0] CYCLES = `RIC_CNT_W'(`RIC_RET_CYCLES)
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic start,
    output logic last
);

    ric_pkg::ric_cnt_state_t s_q;
    ric_pkg::ric_cnt_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (start) begin
            s_d.left = CYCLES;
        end else if (s_q.left != '0) begin
            s_d.left = s_q.left - `RIC_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // High during the final instruction cycle
    assign last = (s_q.left == `RIC_CNT_W'(1));

endmodule // ric_cycle_cnt

/* return_instruction_control_test.sv */
// Self-checking testbench of the return instruction control block.
// Assumes ric_pkg is compiled first and ric_defines.svh is on the include path.
`timescale 1ns/1ps
`include "ric_defines.svh"

module return_instruction_control_test;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    ric_pkg::ric_req_t req = '0;
    logic [`RIC_PC_W-1:0] stack_top = '0;
    logic busy, done, stack_pop, pc_load, w_load, global_irq_enable_set, status_write;
    logic [`RIC_PC_W-1:0] pc_value;
    logic [`RIC_DATA_W-1:0] w_value;
    logic [2:0] irq_control_bit;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    localparam ric_pkg::ric_req_t NO_REQ = '0;

    always #(`RIC_CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    ric_ctrl i_dut (.ref_clk(ref_clk), .resetn(resetn), .req(req), .stack_top(stack_top),
        .busy(busy), .done(done), .stack_pop(stack_pop), .pc_load(pc_load),
        .pc_value(pc_value), .w_load(w_load), .w_value(w_value),
        .global_irq_enable_set(global_irq_enable_set), .irq_control_bit(irq_control_bit),
        .status_write(status_write));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_bit(string n, logic e, logic g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_pc(string n, logic [`RIC_PC_W-1:0] e, logic [`RIC_PC_W-1:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Called at a falling edge; nxt is offered after the take, while still busy
    task automatic issue(ric_pkg::ric_op_t op, logic [7:0] lit, logic [`RIC_PC_W-1:0] top,
                         ric_pkg::ric_req_t nxt);
        logic is_irq;
        logic is_lit;
        is_irq = (op == ric_pkg::RIC_OP_RETURN_FROM_IRQ);
        is_lit = (op == ric_pkg::RIC_OP_RETURN_WITH_LITERAL);
        req = '{valid: 1'b1, op: op, literal: lit};
        stack_top = top;
        @(negedge ref_clk);
        req = nxt;
        stack_top = ~top;
        chk_bit("busy", 1'b1, busy);
        chk_bit("stack_pop", 1'b1, stack_pop);
        chk_bit("pc_load", 1'b1, pc_load);
        chk_pc("pc_value", top, pc_value);
        chk_bit("w_load", is_lit, w_load);
        if (is_lit) begin
            chk_byte("w_value", lit, w_value);
        end
        chk_bit("irq_enable_set", is_irq, global_irq_enable_set);
        chk_byte("irq_bit", 8'h07, {5'h00, irq_control_bit});
        chk_bit("status_write", 1'b0, status_write);
        @(negedge ref_clk);
        chk_bit("busy", 1'b1, busy);
        chk_bit("stack_pop", 1'b0, stack_pop);
        chk_bit("pc_load", 1'b0, pc_load);
        chk_bit("w_load", 1'b0, w_load);
        chk_bit("irq_enable_set", 1'b0, global_irq_enable_set);
        chk_pc("pc_value", top, pc_value);
        @(negedge ref_clk);
        chk_bit("busy", 1'b0, busy);
        chk_bit("done", 1'b1, done);
        chk_bit("status_write", 1'b0, status_write);
    endtask

    task automatic test_none_ignored();
        req = '{valid: 1'b1, op: ric_pkg::RIC_OP_NONE, literal: 8'hA5};
        repeat (3) begin
            @(negedge ref_clk);
            chk_bit("busy", 1'b0, busy);
            chk_bit("stack_pop", 1'b0, stack_pop);
        end
        req = NO_REQ;
        @(negedge ref_clk);
        chk_bit("done", 1'b0, done);
    endtask

    task automatic test_single_ops();
        issue(ric_pkg::RIC_OP_RETURN_SUB, 8'h00, 13'h1ABC, NO_REQ);
        issue(ric_pkg::RIC_OP_RETURN_FROM_IRQ, 8'h00, 13'h0001, NO_REQ);
        issue(ric_pkg::RIC_OP_RETURN_WITH_LITERAL, 8'h5A, 13'h0FFF, NO_REQ);
    endtask

    // Next request held during busy must wait for the done cycle
    task automatic test_back_to_back();
        issue(ric_pkg::RIC_OP_RETURN_WITH_LITERAL, 8'h00, 13'h1FFF,
              '{valid: 1'b1, op: ric_pkg::RIC_OP_RETURN_WITH_LITERAL, literal: 8'hFF});
        issue(ric_pkg::RIC_OP_RETURN_WITH_LITERAL, 8'hFF, 13'h0000,
              '{valid: 1'b1, op: ric_pkg::RIC_OP_RETURN_FROM_IRQ, literal: 8'h00});
        issue(ric_pkg::RIC_OP_RETURN_FROM_IRQ, 8'h00, 13'h1555, NO_REQ);
    endtask

    task automatic test_reset_abort();
        req = '{valid: 1'b1, op: ric_pkg::RIC_OP_RETURN_SUB, literal: 8'h00};
        @(negedge ref_clk);
        req = NO_REQ;
        resetn = 1'b0;
        #1;
        chk_bit("busy", 1'b0, busy);
        chk_bit("pc_load", 1'b0, pc_load);
        @(negedge ref_clk);
        resetn = 1'b1;
    endtask

    initial begin
        repeat (12) @(negedge ref_clk);
        resetn = 1'b1;
        chk_byte("irq_bit", 8'h07, {5'h00, irq_control_bit});
        test_none_ignored();
        test_single_ops();
        test_back_to_back();
        test_reset_abort();
        test_single_ops();
        summarize();
    end
endmodule // return_instruction_control_test
